// >>> logic/csf_core_regs.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
module csf_core_regs (
  input  wire logic                  ref_clk_i,     // 50 MHz core clock
  input  wire logic                  reset_n_i,     // Power-on reset, active low
  input  wire logic [3:0]            addr_i,        // Register address
  input  wire logic [7:0]            wdata_i,       // Write data
  input  wire logic                  wr_i,          // Write strobe
  input  wire logic                  rd_i,          // Read strobe
  output      logic [7:0]            rdata_o,       // Read data, cycle after rd_i
  input  wire logic                  step_i,        // Instruction cycle done
  input  wire logic                  jump_i,        // Jump executing
  input  wire logic                  call_i,        // Call executing
  input  wire logic [8:0]            target_i,      // Instruction address field
  input  wire logic [2:0]            flags_we_i,    // Per-bit update of Z, DC, C
  input  wire logic [2:0]            flags_i,       // New Z, DC, C values
  input  wire logic                  sys_reset_i,   // Non-power-on reset pulse
  input  csf_pkg::csf_cause_e        cause_i,       // Cause of sys_reset_i
  input  wire logic                  timeout_i,     // Timeout flag value at reset
  input  wire logic                  powerdown_i,   // Powerdown flag value at reset
  input  wire logic [5:0]            pin_i,         // Port pin levels
  output      logic [5:0]            pin_o,         // Port output latch
  output      logic [5:0]            pin_oe_n_o,    // Pin drive enable, low drives
  output      logic [9:0]            pc_o,          // Program counter
  output      logic [7:0]            status_o,      // Status register
  output      logic [7:0]            option_o,      // Timer and pull-up options
  output      logic [5:0]            trim_o,        // Oscillator trim
  output      logic [7:0]            timer_o,       // Timer count value
  output      logic [4:0]            pointer_o      // Indirect pointer
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [7:0] status;
    logic [7:0] timer;
    logic [4:0] pointer;
    logic [5:0] trim;
    logic [5:0] port_latch;
    logic [5:0] dir;
    logic [7:0] option;
    logic [7:0] rdata;
  } csf_reg_s;

  csf_reg_s st;
  csf_reg_s next_st;

  csf_pc_if pc_bus ();

  logic [7:0] alu_mask;
  logic [7:0] alu_bits;

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  assign pc_bus.step       = step_i;
  assign pc_bus.jump       = jump_i;
  assign pc_bus.call       = call_i;
  assign pc_bus.target     = target_i;
  assign pc_bus.low_data   = wdata_i;
  assign pc_bus.page       = st.status[csf_pkg::ST_PAGE];
  assign pc_bus.reset_load = sys_reset_i;
  assign pc_bus.low_wr     = wr_i && (addr_i == csf_pkg::OFS_PCL);

  csf_pc_unit u_pc (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .pc_bus    (pc_bus)
  );

  // ----------------------------------------------------------------
  // Flag update from the core
  // ----------------------------------------------------------------
  assign alu_mask = {5'h00, flags_we_i} & csf_pkg::ST_ALU_MASK;
  assign alu_bits = {5'h00, flags_i};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st       = st;
    next_st.sync1 = pin_i;
    next_st.sync2 = st.sync1;
    next_st.rdata = 8'h00;

    next_st.status = (st.status & ~alu_mask) | (alu_bits & alu_mask);

    if (rd_i)
    begin
      unique case (addr_i)
        csf_pkg::OFS_TIMER:
          next_st.rdata = st.timer;
        csf_pkg::OFS_PCL:
          next_st.rdata = pc_bus.pc[7:0];
        csf_pkg::OFS_STATUS:
        begin
          next_st.rdata = st.status;
          next_st.rdata[csf_pkg::ST_UNUSED] = 1'b0;
        end
        csf_pkg::OFS_POINTER:
          next_st.rdata = csf_pkg::PTR_FIXED | {3'h0, st.pointer};
        csf_pkg::OFS_TRIM:
          next_st.rdata = {st.trim, 2'h0};
        csf_pkg::OFS_PORT:
          next_st.rdata = {2'h0, st.sync2};
        default:
          next_st.rdata = 8'h00;
      endcase
    end

    if (wr_i)
    begin
      unique case (addr_i)
        csf_pkg::OFS_TIMER:
          next_st.timer = wdata_i;
        csf_pkg::OFS_STATUS:
          next_st.status = (next_st.status & ~csf_pkg::ST_WR_MASK)
                         | (wdata_i & csf_pkg::ST_WR_MASK);
        csf_pkg::OFS_POINTER:
          next_st.pointer = wdata_i[csf_pkg::PTR_W-1:0];
        csf_pkg::OFS_TRIM:
          next_st.trim = wdata_i[7:2];
        csf_pkg::OFS_PORT:
          next_st.port_latch = wdata_i[csf_pkg::PORT_W-1:0];
        csf_pkg::OFS_DIR:
          next_st.dir = wdata_i[csf_pkg::PORT_W-1:0];
        csf_pkg::OFS_OPTION:
          next_st.option = wdata_i;
        default:
          next_st.timer = next_st.timer;
      endcase
    end

    // Non-power-on reset overrides same-cycle writes to option, direction and status bits 7 to 3
    if (sys_reset_i)
    begin
      next_st.status[csf_pkg::ST_WAKE]    = (cause_i == csf_pkg::CAUSE_WAKE);
      next_st.status[csf_pkg::ST_UNUSED]  = 1'b0;
      next_st.status[csf_pkg::ST_PAGE]    = 1'b0;
      next_st.status[csf_pkg::ST_TIMEOUT] = timeout_i;
      next_st.status[csf_pkg::ST_PWRDN]   = powerdown_i;
      next_st.option                      = csf_pkg::OPTION_RST;
      next_st.dir                         = csf_pkg::DIR_RST;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st.sync1      <= 6'h00;
      st.sync2      <= 6'h00;
      st.status     <= csf_pkg::STATUS_POR;
      st.timer      <= 8'h00;
      st.pointer    <= 5'h00;
      st.trim       <= csf_pkg::TRIM_RST;
      st.port_latch <= 6'h00;
      st.dir        <= csf_pkg::DIR_RST;
      st.option     <= csf_pkg::OPTION_RST;
      st.rdata      <= 8'h00;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o    = st.rdata;
  assign pin_o      = st.port_latch;
  assign pin_oe_n_o = st.dir;
  assign pc_o       = pc_bus.pc;
  assign status_o   = st.status;
  assign option_o   = st.option;
  assign trim_o     = st.trim;
  assign timer_o    = st.timer;
  assign pointer_o  = st.pointer;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_pcl_read;
    rd_i && addr_i == csf_pkg::OFS_PCL |=> rdata_o == $past(pc_bus.pc[7:0]);
  endproperty
  a_pcl_read: assert property (p_pcl_read) else $error("low byte read wrong");

  property p_wake_flag;
    sys_reset_i |=> status_o[csf_pkg::ST_WAKE] == ($past(cause_i) == csf_pkg::CAUSE_WAKE);
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake flag wrong");

  property p_reset_cause_flags;
    sys_reset_i |=> status_o[csf_pkg::ST_TIMEOUT] == $past(timeout_i)
                 && status_o[csf_pkg::ST_PWRDN] == $past(powerdown_i);
  endproperty
  a_reset_cause_flags: assert property (p_reset_cause_flags) else $error("cause flags wrong");

  property p_soft_reset_values;
    sys_reset_i |=> option_o == csf_pkg::OPTION_RST && pin_oe_n_o == csf_pkg::DIR_RST
                 && pc_o[7:0] == csf_pkg::PCL_RST && trim_o == $past(trim_o)
                 && timer_o == $past(timer_o);
  endproperty
  a_soft_reset_values: assert property (p_soft_reset_values) else $error("reset values wrong");

  property p_unused_zero;
    rd_i && (addr_i == csf_pkg::OFS_STATUS || addr_i == csf_pkg::OFS_PORT)
      |=> rdata_o[csf_pkg::ST_UNUSED] == 1'b0
          && ($past(addr_i) != csf_pkg::OFS_PORT || !rdata_o[7]);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit read one");

  property p_page_clear;
    sys_reset_i |=> !status_o[csf_pkg::ST_PAGE];
  endproperty
  a_page_clear: assert property (p_page_clear) else $error("page bit not cleared");

  property p_reset_page_zero_jump;
    sys_reset_i ##1 (step_i && jump_i && !call_i && !wr_i && !sys_reset_i) |=> !pc_o[9];
  endproperty
  a_reset_page_zero_jump: assert property (p_reset_page_zero_jump) else $error("jump left page 0");

endmodule

// >>> logic/csf_pkg.sv
package csf_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int          PC_W        = 10;
  localparam int          ADDR_W      = 4;
  localparam int          PORT_W      = 6;
  localparam int          TRIM_W      = 6;
  localparam int          PTR_W       = 5;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0]  OFS_INDIRECT = 4'h0;
  localparam logic [3:0]  OFS_TIMER    = 4'h1;
  localparam logic [3:0]  OFS_PCL      = 4'h2;
  localparam logic [3:0]  OFS_STATUS   = 4'h3;
  localparam logic [3:0]  OFS_POINTER  = 4'h4;
  localparam logic [3:0]  OFS_TRIM     = 4'h5;
  localparam logic [3:0]  OFS_PORT     = 4'h6;
  localparam logic [3:0]  OFS_DIR      = 4'h8;
  localparam logic [3:0]  OFS_OPTION   = 4'h9;

  // ----------------------------------------------------------------
  // Status field positions and masks
  // ----------------------------------------------------------------
  localparam int          ST_WAKE      = 7;
  localparam int          ST_UNUSED    = 6;
  localparam int          ST_PAGE      = 5;
  localparam int          ST_TIMEOUT   = 4;
  localparam int          ST_PWRDN     = 3;
  localparam logic [7:0]  ST_WR_MASK   = 8'h27;
  localparam logic [7:0]  ST_ALU_MASK  = 8'h07;

  // ----------------------------------------------------------------
  // Reset values and fixed read bits
  // ----------------------------------------------------------------
  localparam logic [9:0]  PC_LAST      = 10'h3FF;
  localparam logic [9:0]  PC_ONE       = 10'h001;
  localparam logic [7:0]  PCL_RST      = 8'hFF;
  localparam logic [7:0]  OPTION_RST   = 8'hFF;
  localparam logic [5:0]  DIR_RST      = 6'h3F;
  localparam logic [7:0]  STATUS_POR   = 8'h18;
  localparam logic [5:0]  TRIM_RST     = 6'h20;
  localparam logic [7:0]  PTR_FIXED    = 8'hE0;

  typedef enum logic [1:0] {
    CAUSE_EXT,
    CAUSE_WDT,
    CAUSE_WAKE
  } csf_cause_e;

endpackage

// >>> logic/csf_pc_if.sv
`timescale 1ns/1ps
interface csf_pc_if;
  logic       step;
  logic       jump;
  logic       call;
  logic       low_wr;
  logic [7:0] low_data;
  logic [8:0] target;
  logic       page;
  logic       reset_load;
  logic [9:0] pc;

  modport ctrl (output step, jump, call, low_wr, low_data, target, page, reset_load,
                input  pc);
  modport unit (input  step, jump, call, low_wr, low_data, target, page, reset_load,
                output pc);
endinterface

// >>> logic/csf_pc_unit.sv
`timescale 1ns/1ps
module csf_pc_unit (
  input  wire logic ref_clk_i,   // Core clock
  input  wire logic reset_n_i,   // Async reset, active low
  csf_pc_if.unit    pc_bus       // Load controls and counter
);

  typedef struct packed {
    logic [csf_pkg::PC_W-1:0] pc;
  } csf_pc_s;

  csf_pc_s st;
  csf_pc_s next_st;

  logic    no_load;

  assign no_load   = !pc_bus.jump && !pc_bus.call && !pc_bus.low_wr && !pc_bus.reset_load;
  assign pc_bus.pc = st.pc;

  // ----------------------------------------------------------------
  // Counter load
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    if (pc_bus.reset_load)
      next_st.pc = csf_pkg::PC_LAST;
    else if (pc_bus.low_wr)
      next_st.pc = {pc_bus.page, 1'b0, pc_bus.low_data};
    else if (pc_bus.step)
    begin
      if (pc_bus.call)
        next_st.pc = {pc_bus.page, 1'b0, pc_bus.target[7:0]};
      else if (pc_bus.jump)
        next_st.pc = {pc_bus.page, pc_bus.target};
      else if (st.pc == csf_pkg::PC_LAST)
        next_st.pc = '0;
      else
        next_st.pc = st.pc + csf_pkg::PC_ONE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      st <= '{pc: csf_pkg::PC_LAST};
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_pc_advance;
    pc_bus.step && no_load && st.pc != csf_pkg::PC_LAST |=> st.pc == $past(st.pc) + csf_pkg::PC_ONE;
  endproperty
  a_pc_advance: assert property (p_pc_advance) else $error("pc did not advance");

  property p_jump_load;
    pc_bus.step && pc_bus.jump && !pc_bus.call && !pc_bus.low_wr && !pc_bus.reset_load
      |=> st.pc == {$past(pc_bus.page), $past(pc_bus.target)};
  endproperty
  a_jump_load: assert property (p_jump_load) else $error("jump load wrong");

  property p_low_write;
    pc_bus.low_wr && !pc_bus.reset_load
      |=> !st.pc[8] && st.pc[7:0] == $past(pc_bus.low_data) && st.pc[9] == $past(pc_bus.page);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low byte load wrong");

  property p_wrap;
    pc_bus.step && no_load && st.pc == csf_pkg::PC_LAST |=> st.pc == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pc did not wrap");

  property p_reset_rollover;
    pc_bus.reset_load ##1 (pc_bus.step && no_load) |=> st.pc == '0;
  endproperty
  a_reset_rollover: assert property (p_reset_rollover) else $error("no rollover");

endmodule

// >>> sim/csf_core_model.sv
`timescale 1ns/1ps
module csf_core_model (
  input  wire logic       ref_clk_i,   // Core clock
  output      logic       step_o,      // Instruction cycle done
  output      logic       jump_o,      // Jump executing
  output      logic       call_o,      // Call executing
  output      logic [8:0] target_o,    // Instruction address field
  output      logic [2:0] flags_we_o,  // Flag write enables
  output      logic [2:0] flags_o      // New flag values
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial
  begin
    step_o     = 1'b0;
    jump_o     = 1'b0;
    call_o     = 1'b0;
    target_o   = 9'h155;
    flags_we_o = 3'h0;
    flags_o    = 3'h5;
  end

  // ----------------------------------------------------------------
  // One instruction cycle
  // ----------------------------------------------------------------
  task automatic run(input logic j, input logic c, input logic [8:0] t,
                     input logic [2:0] fwe, input logic [2:0] fv);
    @(posedge ref_clk_i);
    step_o     <= 1'b1;
    jump_o     <= j;
    call_o     <= c;
    target_o   <= t;
    flags_we_o <= fwe;
    flags_o    <= fv;
    @(posedge ref_clk_i);
    step_o     <= 1'b0;
    jump_o     <= 1'b0;
    call_o     <= 1'b0;
    flags_we_o <= 3'h0;
    // Released fields show no stale value
    target_o   <= ~t;
    flags_o    <= ~fv;
  endtask
endmodule

// >>> sim/core_sfr_and_program_counter_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %0t: got %h exp %h", $time, (g), (e)); end end
module core_sfr_and_program_counter_tb;
  logic                ref_clk_i;
  logic                reset_n_i;
  logic [3:0]          addr_i;
  logic [7:0]          wdata_i;
  logic                wr_i;
  logic                rd_i;
  logic [7:0]          rdata_o;
  logic                step_i;
  logic                jump_i;
  logic                call_i;
  logic [8:0]          target_i;
  logic [2:0]          flags_we_i;
  logic [2:0]          flags_i;
  logic                sys_reset_i;
  csf_pkg::csf_cause_e cause_i;
  logic                timeout_i;
  logic                powerdown_i;
  logic [5:0]          pin_ext;
  wire  logic [5:0]    pin_lvl;
  logic [5:0]          pin_o;
  logic [5:0]          pin_oe_n_o;
  logic [9:0]          pc_o;
  logic [7:0]          status_o;
  logic [7:0]          option_o;
  logic [5:0]          trim_o;
  logic [7:0]          timer_o;
  logic [4:0]          pointer_o;
  logic [2:0]          fl;
  csf_pkg::csf_cause_e causes [4];
  int                  err_count;
  int                  compares;

  // Driven bits follow the latch, the rest the outside level
  assign pin_lvl = (~pin_oe_n_o & pin_o) | (pin_oe_n_o & pin_ext);

  always #10 ref_clk_i = ~ref_clk_i;

  csf_core_model core (
    .ref_clk_i  (ref_clk_i),
    .step_o     (step_i),
    .jump_o     (jump_i),
    .call_o     (call_i),
    .target_o   (target_i),
    .flags_we_o (flags_we_i),
    .flags_o    (flags_i)
  );

  csf_core_regs DUT (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .addr_i      (addr_i),
    .wdata_i     (wdata_i),
    .wr_i        (wr_i),
    .rd_i        (rd_i),
    .rdata_o     (rdata_o),
    .step_i      (step_i),
    .jump_i      (jump_i),
    .call_i      (call_i),
    .target_i    (target_i),
    .flags_we_i  (flags_we_i),
    .flags_i     (flags_i),
    .sys_reset_i (sys_reset_i),
    .cause_i     (cause_i),
    .timeout_i   (timeout_i),
    .powerdown_i (powerdown_i),
    .pin_i       (pin_lvl),
    .pin_o       (pin_o),
    .pin_oe_n_o  (pin_oe_n_o),
    .pc_o        (pc_o),
    .status_o    (status_o),
    .option_o    (option_o),
    .trim_o      (trim_o),
    .timer_o     (timer_o),
    .pointer_o   (pointer_o)
  );

  // ----------------------------------------------------------------
  // Bus and core tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
    wdata_i <= ~d;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    `CHK(rdata_o, e)
  endtask

  task automatic step_chk(input logic j, input logic c, input logic [8:0] t,
                          input logic [9:0] e);
    core.run(j, c, t, 3'h0, 3'h0);
    #1;
    `CHK(pc_o, e)
  endtask

  task automatic sreset(input csf_pkg::csf_cause_e c, input logic to, input logic pd);
    @(posedge ref_clk_i);
    sys_reset_i <= 1'b1;
    cause_i     <= c;
    timeout_i   <= to;
    powerdown_i <= pd;
    @(posedge ref_clk_i);
    sys_reset_i <= 1'b0;
    cause_i     <= csf_pkg::CAUSE_WDT;
    #1;
  endtask

  task automatic report_and_stop();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk_i   = 1'b0;
    reset_n_i   = 1'b0;
    addr_i      = 4'h0;
    wdata_i     = 8'h00;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    sys_reset_i = 1'b0;
    cause_i     = csf_pkg::CAUSE_EXT;
    timeout_i   = 1'b0;
    powerdown_i = 1'b0;
    pin_ext     = 6'h2A;
    err_count   = 0;
    compares    = 0;
    causes      = '{csf_pkg::CAUSE_WAKE, csf_pkg::CAUSE_EXT, csf_pkg::CAUSE_WAKE,
                    csf_pkg::CAUSE_WDT};
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    #1;
    `CHK(pc_o, 10'h3FF)
    `CHK(status_o, 8'h18)
    `CHK(option_o, 8'hFF)
    `CHK(pin_oe_n_o, 6'h3F)
    rd_chk(4'h2, 8'hFF);
    @(posedge ref_clk_i);
    #1;
    `CHK(rdata_o, 8'h00)
    step_chk(1'b0, 1'b0, 9'h000, 10'h000);
    step_chk(1'b0, 1'b0, 9'h000, 10'h001);
    step_chk(1'b1, 1'b0, 9'h1AB, 10'h1AB);
    wr(4'h3, 8'h20);
    step_chk(1'b1, 1'b0, 9'h055, 10'h255);
    step_chk(1'b1, 1'b1, 9'h1C3, 10'h2C3);
    wr(4'h2, 8'h7E);
    #1;
    `CHK(pc_o, 10'h27E)
    rd_chk(4'h2, 8'h7E);
    step_chk(1'b1, 1'b0, 9'h1FF, 10'h3FF);
    rd_chk(4'h2, 8'hFF);
    rd_chk(4'hF, 8'h00);
    step_chk(1'b0, 1'b0, 9'h000, 10'h000);
    wr(4'h3, 8'hFF);
    rd_chk(4'h3, 8'h3F);
    wr(4'h1, 8'h5A);
    wr(4'h4, 8'h13);
    wr(4'h5, 8'hA4);
    for (int i = 0; i < 4; i++)
    begin
      fl = {1'b0, i[0], 1'b1};
      wr(4'h9, 8'h12);
      wr(4'h8, 8'h05);
      wr(4'h3, 8'h20);
      core.run(1'b0, 1'b0, 9'h000, 3'h7, fl);
      #1;
      `CHK(option_o, 8'h12)
      sreset(causes[i], i[0], ~i[0]);
      `CHK(pc_o, 10'h3FF)
      `CHK(status_o, {causes[i] == csf_pkg::CAUSE_WAKE, 2'b00, i[0], ~i[0], fl})
      `CHK(option_o, 8'hFF)
      `CHK(pin_oe_n_o, 6'h3F)
      `CHK(timer_o, 8'h5A)
      rd_chk(4'h2, 8'hFF);
    end
    `CHK(pointer_o, 5'h13)
    `CHK(trim_o, 6'h29)
    wr(4'h8, 8'h05);
    wr(4'h6, 8'h15);
    #1;
    `CHK(pin_o, 6'h15)
    repeat (3) @(posedge ref_clk_i);
    rd_chk(4'h6, {2'b00, (~6'h05 & 6'h15) | (6'h05 & pin_ext)});
    for (int j = 1; j >= 0; j--)
    begin
      wr(4'h3, 8'h20);
      fork
        sreset(csf_pkg::CAUSE_EXT, 1'b0, 1'b0);
        begin
          @(posedge ref_clk_i);
          core.run(j[0], 1'b0, 9'h0AB, 3'h0, 3'h0);
        end
      join
      #1;
      `CHK(pc_o, j[0] ? 10'h0AB : 10'h000)
    end
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    #1;
    `CHK(pc_o, 10'h3FF)
    `CHK(status_o, 8'h18)
    @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    step_chk(1'b0, 1'b0, 9'h000, 10'h000);
    report_and_stop();
  end

  initial
  begin
    #200000;
    err_count++;
    report_and_stop();
  end
endmodule
